// ==== rtl/pcwd_pkg.sv ====
// package of constants for the pll configuration word decoder
package pcwd_pkg;
  localparam logic [7:0] PCWD_ADDR_CFG_WORD = 8'h00;
  localparam logic [7:0] PCWD_ADDR_DECODED = 8'h04;
  localparam logic [7:0] PCWD_ADDR_RESET_CAUSE = 8'h08;
  localparam logic [7:0] PCWD_ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] PCWD_ADDR_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] PCWD_ADDR_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] PCWD_ADDR_RUN_STATUS = 8'h18;
  localparam int PCWD_ODIV_LSB = 16;
  localparam int PCWD_USB_DIS_BIT = 15;
  localparam int PCWD_UDIV_LSB = 8;
  localparam int PCWD_MUL_LSB = 4;
  localparam int PCWD_IDIV_LSB = 0;
  localparam logic [31:0] PCWD_RSVD_MASK = 32'hfff8_7888;
  localparam logic [31:0] PCWD_CFG_RESET = 32'hffff_ffff;
  localparam int PCWD_BROWNOUT_BIT = 1;
  localparam int PCWD_IRQ_BROWNOUT_BIT = 0;
  localparam int PCWD_IRQ_RUN_BIT = 1;
  localparam int PCWD_PWRUP_NS = 10000;
  localparam int PCWD_CLK_MHZ = 200;
  localparam int PCWD_PWRUP_CYCLES = (PCWD_PWRUP_NS * PCWD_CLK_MHZ + 999) / 1000;
  localparam logic [31:0] PCWD_CFG_CAPTURE_CNT = 32'h2;
  localparam logic [1:0] PCWD_RESP_OKAY = 2'b00;
  localparam logic [1:0] PCWD_RESP_SLVERR = 2'b10;
endpackage

// ==== rtl/pcwd_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps
module pcwd_sync
#(
  parameter int W = 1
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      q <= '0;
    end
    else
    begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule

// ==== rtl/pcwd_top.sv ====
// pll configuration word decoder with power-up hold and brown-out capture
// How it works
// - output divisor code selects 1..64, or 256
// - multiplier code selects 15..21, or 24
// - usb input divider selects 1..6,10,12
// - usb disable bit one disables and bypasses
// - usb fields only act with usb present
// - hold execution for regulator start-up delay
// - supply failure issues a brown-out reset
// - brown-out sets reset cause bit one
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module pcwd_top
  import pcwd_pkg::*;
#(
  parameter bit HAS_USB = 1'b1,
  parameter int PWRUP_CYCLES = PCWD_PWRUP_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [31:0] cfg_word_in,
  input wire logic power_resume,
  input wire logic supply_low,
  output logic [8:0] pll_output_divisor,
  output logic [4:0] pll_multiplier,
  output logic [3:0] usb_pll_input_divider,
  output logic usb_pll_enable,
  output logic usb_pll_bypass,
  output logic [2:0] pll_input_divider_sel,
  output logic cfg_reserved_error,
  output logic run_enable,
  output logic brownout_reset_req,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pcwd_pkg::*;

  typedef enum logic [1:0]
  {
    PCWD_ST_HOLD = 2'b00,
    PCWD_ST_RUN = 2'b01
  } pcwd_state_t;

  logic [31:0] cfg_sync;
  logic [1:0] pin_sync;
  logic resume_s;
  logic low_s;
  logic resume_prev_q;
  logic [31:0] cfg_q;
  pcwd_state_t state_q;
  pcwd_state_t state_d;
  logic [31:0] pwrup_cnt_q;
  logic [31:0] pwrup_cnt_d;
  logic brownout_reset_flag_q;
  logic brownout_req_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic [8:0] odiv_q;
  logic [4:0] mul_q;
  logic [3:0] udiv_q;
  logic uen_q;
  logic ubyp_q;
  logic [2:0] idiv_q;
  logic rsvd_err_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // pin synchronisers
  pcwd_sync #(.W(32)) u_cfg_sync
  (
    .clock(clock),
    .rst_n(rst_n),
    .d(cfg_word_in),
    .q(cfg_sync)
  );

  pcwd_sync #(.W(2)) u_pin_sync
  (
    .clock(clock),
    .rst_n(rst_n),
    .d({supply_low, power_resume}),
    .q(pin_sync)
  );

  assign resume_s = pin_sync[0];
  assign low_s = pin_sync[1];
  wire hold = (state_q == PCWD_ST_HOLD);
  wire running = (state_q == PCWD_ST_RUN);
  wire cfg_capture = hold & (pwrup_cnt_q == PCWD_CFG_CAPTURE_CNT);

  // code decode tables
  wire [2:0] odiv_code = cfg_q[PCWD_ODIV_LSB +: 3];
  wire [2:0] mul_code = cfg_q[PCWD_MUL_LSB +: 3];
  wire [2:0] udiv_code = cfg_q[PCWD_UDIV_LSB +: 3];
  wire usb_dis_bit = cfg_q[PCWD_USB_DIS_BIT];
  wire [8:0] odiv_val = (odiv_code == 3'h7) ? 9'h100 : (9'h001 << odiv_code);
  wire [4:0] mul_val = (mul_code == 3'h7) ? 5'h18 : (5'h0f + {2'b00, mul_code});
  wire [3:0] udiv_val = (udiv_code == 3'h7) ? 4'hc :
                        (udiv_code == 3'h6) ? 4'ha : ({1'b0, udiv_code} + 4'h1);
  wire uen_val = HAS_USB & ~usb_dis_bit;
  wire ubyp_val = ~HAS_USB | usb_dis_bit;
  wire rsvd_err_val = ((cfg_q & PCWD_RSVD_MASK) != PCWD_RSVD_MASK);

  // word captured once per hold, after the synchronisers have settled
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cfg_q <= PCWD_CFG_RESET;
    else if (cfg_capture)
      cfg_q <= cfg_sync;
  end

  // decoded settings, frozen while running
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      odiv_q <= 9'h001;
      mul_q <= 5'h0f;
      udiv_q <= 4'h1;
      uen_q <= 1'b0;
      ubyp_q <= 1'b1;
      idiv_q <= 3'h0;
      rsvd_err_q <= 1'b0;
    end
    else if (hold)
    begin
      odiv_q <= odiv_val;
      mul_q <= mul_val;
      udiv_q <= HAS_USB ? udiv_val : 4'h1;
      uen_q <= uen_val;
      ubyp_q <= ubyp_val;
      idiv_q <= cfg_q[PCWD_IDIV_LSB +: 3];
      rsvd_err_q <= rsvd_err_val;
    end
  end

  // power-up hold sequencer
  wire resume_evt = resume_s & ~resume_prev_q;
  always_comb
  begin
    state_d = state_q;
    pwrup_cnt_d = pwrup_cnt_q;
    unique case (state_q)
      PCWD_ST_HOLD:
      begin
        if (low_s)
          pwrup_cnt_d = 32'h0;
        else if (pwrup_cnt_q >= PWRUP_CYCLES - 1)
          state_d = PCWD_ST_RUN;
        else
          pwrup_cnt_d = pwrup_cnt_q + 32'h1;
      end
      PCWD_ST_RUN:
      begin
        if (resume_evt || low_s)
        begin
          state_d = PCWD_ST_HOLD;
          pwrup_cnt_d = 32'h0;
        end
      end
      default:
      begin
        state_d = PCWD_ST_HOLD;
        pwrup_cnt_d = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q <= PCWD_ST_HOLD;
      pwrup_cnt_q <= 32'h0;
      resume_prev_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pwrup_cnt_q <= pwrup_cnt_d;
      resume_prev_q <= resume_s;
    end
  end

  // axi write path
  wire aw_take = s_axi_awvalid & ~aw_have_q & ~bvalid_q;
  wire w_take = s_axi_wvalid & ~w_have_q & ~bvalid_q;
  wire aw_ok = aw_have_q | aw_take;
  wire w_ok = w_have_q | w_take;
  wire wr_fire = aw_ok & w_ok & ~bvalid_q;
  wire [7:0] wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_have_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_have_q ? wstrb_q : s_axi_wstrb;
  wire wr_en = wr_fire & (wr_addr == PCWD_ADDR_IRQ_ENABLE) & wr_strb[0];
  wire wr_clr = wr_fire & (wr_addr == PCWD_ADDR_IRQ_CLEAR) & wr_strb[0];
  wire wr_known = (wr_addr == PCWD_ADDR_IRQ_ENABLE) | (wr_addr == PCWD_ADDR_IRQ_CLEAR);
  wire [1:0] clr_bits = wr_clr ? wr_data[1:0] : 2'b00;
  wire brownout_evt = low_s & ~brownout_req_q;
  wire run_evt = hold & (state_d == PCWD_ST_RUN);
  wire [1:0] set_bits = {run_evt, brownout_evt};

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= PCWD_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? PCWD_RESP_OKAY : PCWD_RESP_SLVERR;
      end
      else
      begin
        aw_have_q <= aw_ok;
        w_have_q <= w_ok;
        if (s_axi_bready)
          bvalid_q <= 1'b0;
      end
    end
  end

  // brown-out capture and interrupt status, set wins over clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      brownout_reset_flag_q <= 1'b0;
      brownout_req_q <= 1'b0;
      irq_stat_q <= 2'b00;
      irq_en_q <= 2'b00;
    end
    else
    begin
      brownout_req_q <= low_s;
      if (brownout_evt)
        brownout_reset_flag_q <= 1'b1;
      irq_stat_q <= (irq_stat_q & ~clr_bits) | set_bits;
      if (wr_en)
        irq_en_q <= wr_data[1:0];
    end
  end

  // axi read path
  wire rd_fire = s_axi_arvalid & ~rvalid_q;
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] dec_word = {9'h000, ubyp_q, uen_q, udiv_q, mul_q, odiv_q, idiv_q};
  wire rd_known = (ra == PCWD_ADDR_CFG_WORD) | (ra == PCWD_ADDR_DECODED) | (ra == PCWD_ADDR_RESET_CAUSE) |
                  (ra == PCWD_ADDR_IRQ_STATUS) | (ra == PCWD_ADDR_IRQ_ENABLE) | (ra == PCWD_ADDR_IRQ_CLEAR) |
                  (ra == PCWD_ADDR_RUN_STATUS);
  wire [31:0] rd_val = (ra == PCWD_ADDR_CFG_WORD) ? cfg_q :
                       (ra == PCWD_ADDR_DECODED) ? dec_word :
                       (ra == PCWD_ADDR_RESET_CAUSE) ? ({31'h0, brownout_reset_flag_q} << PCWD_BROWNOUT_BIT) :
                       (ra == PCWD_ADDR_IRQ_STATUS) ? {30'h0, irq_stat_q} :
                       (ra == PCWD_ADDR_IRQ_ENABLE) ? {30'h0, irq_en_q} :
                       (ra == PCWD_ADDR_RUN_STATUS) ? {30'h0, rsvd_err_q, running} :
                       32'h0;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= PCWD_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_known ? PCWD_RESP_OKAY : PCWD_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // register bus outputs
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready = ~w_have_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // pin outputs
  assign pll_output_divisor = odiv_q;
  assign pll_multiplier = mul_q;
  assign usb_pll_input_divider = udiv_q;
  assign usb_pll_enable = uen_q;
  assign usb_pll_bypass = ubyp_q;
  assign pll_input_divider_sel = idiv_q;
  assign cfg_reserved_error = rsvd_err_q;
  assign run_enable = running;
  assign brownout_reset_req = brownout_req_q;
  // level interrupt from enabled status bits
  wire [1:0] irq_pending = irq_stat_q & irq_en_q;
  assign irq = |irq_pending;
endmodule

// ==== bench/pcwd_properties.sv ====
// port checks for the pll configuration word decoder
`timescale 1ns/1ps
module pcwd_properties
#(
  parameter int PWRUP_CYCLES = 8
)
(
  input logic clock,
  input logic rst_n,
  input logic supply_low,
  input logic [8:0] pll_output_divisor,
  input logic [4:0] pll_multiplier,
  input logic usb_pll_enable,
  input logic usb_pll_bypass,
  input logic run_enable,
  input logic brownout_reset_req,
  input logic s_axi_bvalid,
  input logic s_axi_bready
);
  logic [15:0] low_q;
  always_ff @(posedge clock)
    low_q <= (!rst_n || run_enable) ? 16'h0000 : low_q + 16'h0001;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_odiv; $onehot(pll_output_divisor) && !pll_output_divisor[7]; endproperty
  a_odiv: assert property (p_odiv) else $error("bad divisor");
  property p_mul; pll_multiplier inside {[5'h0f:5'h15], 5'h18}; endproperty
  a_mul: assert property (p_mul) else $error("bad multiplier");
  property p_usb; usb_pll_enable != usb_pll_bypass; endproperty
  a_usb: assert property (p_usb) else $error("usb enable and bypass agree");
  property p_frz; run_enable && $past(run_enable) |-> $stable(pll_output_divisor) && $stable(pll_multiplier); endproperty
  a_frz: assert property (p_frz) else $error("settings moved while running");
  property p_hold; $rose(run_enable) |-> low_q >= PWRUP_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("start-up hold too short");
  property p_bor; $rose(supply_low) |-> ##[1:4] brownout_reset_req; endproperty
  a_bor: assert property (p_bor) else $error("no brown-out reset");
  property p_run; $rose(brownout_reset_req) |-> ##[0:2] !run_enable; endproperty
  a_run: assert property (p_run) else $error("still running in brown-out");
  property p_brown_hold; brownout_reset_req |-> !run_enable; endproperty
  a_brown_hold: assert property (p_brown_hold) else $error("ran during brown-out");
  property p_bstand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bstand: assert property (p_bstand) else $error("write answer dropped");
  c_run: cover property ($rose(run_enable));
  c_bor: cover property ($rose(brownout_reset_req));
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind pcwd_top pcwd_properties #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_chk
(
  .clock(clock),
  .rst_n(rst_n),
  .supply_low(supply_low),
  .pll_output_divisor(pll_output_divisor),
  .pll_multiplier(pll_multiplier),
  .usb_pll_enable(usb_pll_enable),
  .usb_pll_bypass(usb_pll_bypass),
  .run_enable(run_enable),
  .brownout_reset_req(brownout_reset_req),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready)
);

// ==== bench/tb_pcwd_top.sv ====
// self-checking bench for the pll configuration word decoder
`timescale 1ns/1ps
module tb_pcwd_top;
  import pcwd_pkg::*;
  logic clock = 0, rst_n = 0, power_resume = 0, supply_low = 0;
  logic [31:0] cfg_word_in = 32'hffff_ffff;
  logic [8:0] pll_output_divisor;
  logic [4:0] pll_multiplier;
  logic [3:0] usb_pll_input_divider;
  logic [2:0] pll_input_divider_sel;
  logic usb_pll_enable, usb_pll_bypass, cfg_reserved_error, run_enable, brownout_reset_req, irq;
  logic [3:0] nousb_udiv;
  logic nousb_enable, nousb_bypass;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_mismatch = 0, compares = 0;
  logic [20:0] rows [8] = '{{3'h0, 9'h001, 5'h0f, 4'h1}, {3'h1, 9'h002, 5'h10, 4'h2},
    {3'h2, 9'h004, 5'h11, 4'h3}, {3'h3, 9'h008, 5'h12, 4'h4}, {3'h4, 9'h010, 5'h13, 4'h5},
    {3'h5, 9'h020, 5'h14, 4'h6}, {3'h6, 9'h040, 5'h15, 4'ha}, {3'h7, 9'h100, 5'h18, 4'hc}};
  pcwd_top #(.HAS_USB(1'b1), .PWRUP_CYCLES(8)) u_pcwd_top
  (
    .clock(clock),
    .rst_n(rst_n),
    .cfg_word_in(cfg_word_in),
    .power_resume(power_resume),
    .supply_low(supply_low),
    .pll_output_divisor(pll_output_divisor),
    .pll_multiplier(pll_multiplier),
    .usb_pll_input_divider(usb_pll_input_divider),
    .usb_pll_enable(usb_pll_enable),
    .usb_pll_bypass(usb_pll_bypass),
    .pll_input_divider_sel(pll_input_divider_sel),
    .cfg_reserved_error(cfg_reserved_error),
    .run_enable(run_enable),
    .brownout_reset_req(brownout_reset_req),
    .irq(irq),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  // variant without the usb function, same stimulus
  pcwd_top #(.HAS_USB(1'b0), .PWRUP_CYCLES(8)) u_pcwd_top_nousb
  (
    .clock(clock),
    .rst_n(rst_n),
    .cfg_word_in(cfg_word_in),
    .power_resume(power_resume),
    .supply_low(supply_low),
    .pll_output_divisor(),
    .pll_multiplier(),
    .usb_pll_input_divider(nousb_udiv),
    .usb_pll_enable(nousb_enable),
    .usb_pll_bypass(nousb_bypass),
    .pll_input_divider_sel(),
    .cfg_reserved_error(),
    .run_enable(),
    .brownout_reset_req(),
    .irq(),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(),
    .s_axi_bresp(),
    .s_axi_bvalid(),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(),
    .s_axi_rdata(),
    .s_axi_rresp(),
    .s_axi_rvalid(),
    .s_axi_rready(s_axi_rready)
  );
  always #2.5 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 200)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic wv(ref logic s, input logic v);
    int k;
    for (k = 0; k < 200 && s !== v; k++)
      @(posedge clock);
    tmo(k);
  endtask
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (k = 0; k < 200; k++)
    begin
      @(posedge clock);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    tmo(k);
    chk(32'(wr ? s_axi_bresp : s_axi_rresp), 32'(r));
    if (!wr)
      chk(s_axi_rdata, d);
  endtask
  task automatic resume(input logic [31:0] w);
    cfg_word_in <= w;
    repeat (4) @(posedge clock);
    power_resume <= 1'b1;
    wv(run_enable, 1'b0);
    power_resume <= 1'b0;
    wv(run_enable, 1'b1);
  endtask
  initial
  begin
    logic [2:0] c;
    repeat (5) @(posedge clock);
    chk(32'({pll_output_divisor, pll_multiplier, usb_pll_bypass, run_enable}), 32'({9'h001, 5'h0f, 2'h2}));
    @(posedge clock);
    rst_n <= 1'b1;
    wv(run_enable, 1'b1);
    chk(32'({pll_output_divisor, pll_multiplier, usb_pll_input_divider, cfg_reserved_error}), 32'({9'h100, 5'h18, 4'hc, 1'b0}));
    for (int i = 0; i < 8; i++)
    begin
      c = rows[i][20:18];
      resume(PCWD_RSVD_MASK | {13'h0, c, c[0], 4'h0, c, 1'h0, c, 1'h0, c});
      chk(32'({pll_output_divisor, pll_multiplier, usb_pll_input_divider}), 32'(rows[i][17:0]));
      chk(32'({usb_pll_bypass, usb_pll_enable, pll_input_divider_sel}), 32'({c[0], !c[0], c}));
      chk(32'({nousb_bypass, nousb_enable, nousb_udiv}), 32'({1'b1, 1'b0, 4'h1}));
      cfg_word_in <= 32'h0;
      repeat (6) @(posedge clock);
      chk(32'({pll_output_divisor, pll_multiplier, usb_pll_input_divider}), 32'(rows[i][17:0]));
    end
    axi(1'b0, PCWD_ADDR_DECODED, 32'h0059_8807, PCWD_RESP_OKAY);
    axi(1'b0, PCWD_ADDR_CFG_WORD, 32'hffff_ffff, PCWD_RESP_OKAY);
    axi(1'b1, PCWD_ADDR_CFG_WORD, 32'h0, PCWD_RESP_SLVERR);
    axi(1'b0, 8'h40, 32'h0, PCWD_RESP_SLVERR);
    resume(PCWD_RSVD_MASK & 32'hffff_fff7);
    chk(32'(cfg_reserved_error), 32'h1);
    axi(1'b0, PCWD_ADDR_RUN_STATUS, 32'h3, PCWD_RESP_OKAY);
    axi(1'b1, PCWD_ADDR_IRQ_CLEAR, 32'h3, PCWD_RESP_OKAY);
    axi(1'b1, PCWD_ADDR_IRQ_ENABLE, 32'h1, PCWD_RESP_OKAY);
    chk(32'(irq), 32'h0);
    supply_low <= 1'b1;
    wv(brownout_reset_req, 1'b1);
    wv(irq, 1'b1);
    repeat (12)
    begin
      @(posedge clock);
      chk(32'(run_enable), 32'h0);
    end
    supply_low <= 1'b0;
    wv(run_enable, 1'b1);
    axi(1'b0, PCWD_ADDR_RESET_CAUSE, 32'h2, PCWD_RESP_OKAY);
    axi(1'b0, PCWD_ADDR_IRQ_STATUS, 32'h3, PCWD_RESP_OKAY);
    axi(1'b1, PCWD_ADDR_IRQ_ENABLE, 32'h0, PCWD_RESP_OKAY);
    chk(32'(irq), 32'h0);
    axi(1'b1, PCWD_ADDR_IRQ_ENABLE, 32'h1, PCWD_RESP_OKAY);
    chk(32'(irq), 32'h1);
    axi(1'b1, PCWD_ADDR_IRQ_CLEAR, 32'h1, PCWD_RESP_OKAY);
    chk(32'(irq), 32'h0);
    rst_n <= 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    axi(1'b0, PCWD_ADDR_RESET_CAUSE, 32'h0, PCWD_RESP_OKAY);
    test_done();
  end
endmodule
